// file: logic/dma_ctrl_pkg.sv
// constants, field layouts and carrier types of the descriptor queue
// controller; assumes a single application clock domain
`default_nettype none

package dma_ctrl_pkg;

    // ========================================
    // widths
    localparam int REG_W = 512;
    localparam int BE_W = 64;
    localparam int ADDR_W = 16;
    localparam int DESC_W = 174;
    localparam int STS_W = 32;
    localparam int FILL_W = 8;
    localparam int NUM_CH = 4;
    localparam int NUM_MOVER = 2;
    localparam int STS_DEPTH = 32;

    // ========================================
    // register map, one 512-bit register per 0x200 bytes
    localparam logic [15:0] OFS_WRITE_MOVER_NORMAL_QUEUE = 16'h0000;
    localparam logic [15:0] OFS_WRITE_MOVER_PRIORITY_QUEUE = 16'h0200;
    localparam logic [15:0] OFS_WRITE_MOVER_STATUS_QUEUE = 16'h0400;
    localparam logic [15:0] OFS_WRITE_MOVER_MSI_CONTROL = 16'h0600;
    localparam logic [15:0] OFS_READ_MOVER_NORMAL_QUEUE = 16'h0800;
    localparam logic [15:0] OFS_READ_MOVER_PRIORITY_QUEUE = 16'h0a00;
    localparam logic [15:0] OFS_READ_MOVER_STATUS_QUEUE = 16'h0c00;
    localparam logic [15:0] OFS_READ_MOVER_MSI_CONTROL = 16'h0e00;
    localparam int SEL_LSB = 9;
    localparam int SEL_W = 3;
    localparam int MAP_TOP_LSB = 12;
    localparam logic [1:0] SEL_KIND_STATUS = 2'h2;
    localparam logic [1:0] SEL_KIND_MSI = 2'h3;

    // ========================================
    // queue register read layout
    localparam int READY_BIT = 31;
    // byte lanes of the most significant descriptor dword (bits 191:160)
    localparam int MSW_BE_LSB = 20;
    localparam int MSW_BE_W = 4;

    // ========================================
    // status word layout
    localparam int STS_EMPTY_BIT = 31;
    localparam int STS_IRQ_LSB = 12;
    localparam int STS_ERR_BIT = 14;
    localparam logic [1:0] IRQ_ALWAYS = 2'h3;
    localparam logic [1:0] IRQ_ON_ERROR = 2'h2;
    localparam logic [1:0] IRQ_NEVER = 2'h1;
    localparam logic [1:0] IRQ_DROP = 2'h0;
    localparam logic [REG_W-1:0] STS_EMPTY_WORD = 512'h8000_0000;

    // ========================================
    // msi control register layout
    localparam int MSI_EN_BIT = 511;
    localparam int MSI_PRIO_BIT = 510;
    localparam int MSI_DATA_LSB = 80;
    localparam int MSI_ADDR_LSB = 0;

    // ========================================
    // immediate-write descriptor built for an msi
    localparam int DESC_DST_LSB = 64;
    localparam int DESC_LEN_LSB = 128;
    localparam int DESC_LEN_W = 18;
    localparam logic [17:0] MSI_LEN_DWORDS = 18'h00001;
    localparam int DESC_IMM_BIT = 146;
    localparam int DESC_APP_LSB = 149;
    localparam logic [2:0] APP_DROP_NO_IRQ = 3'h0;

    typedef logic [DESC_W-1:0] desc_t;

    typedef struct packed {
        logic enable;
        logic prio;
        logic [15:0] data;
        logic [63:0] addr;
    } msi_ctrl_t;

    typedef struct packed {
        logic valid;
        logic [STS_W-1:0] word;
    } status_t;

    localparam msi_ctrl_t MSI_RESET = '0;

endpackage : dma_ctrl_pkg

`default_nettype wire

// file: logic/dma_descriptor_queue_controller.sv
// descriptor queue controller with its status fifo
// assumes movers and register master share core_clk
//
// What this block does
// - every register is 512 bits wide
// - descriptors occupy low 174 bits, mover layout
// - shadow buffer, forward on most significant dword
// - hold waitrequest on most significant dword write while mover not ready
// - queue read: ready bit31, fill bits 7:0
// - status reads meaningful only in low dword
// - empty status queue reads 512'h8000_0000
// - msi control: enable, priority, data, address
// - enable gates msi, priority picks queue
// - bits 13:12 select interrupt and drop
// - decide on arrival, queue immediate-write msi
// - msi descriptors carry no-interrupt-drop code
// - lowest application bit requests completion interrupt
// - everything runs on one application clock
`default_nettype none

// ========================================
// status fifo
module status_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
        begin : g_bad_depth
            $error("status_fifo depth must be a power of two");
        end
    endgenerate

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    assign in_ready = (cnt_q != (AW + 1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb
    begin
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
    end

    always_ff @(posedge core_clk)
    begin
        if (push)
        begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end
endmodule : status_fifo

// ========================================
// controller top
module dma_descriptor_queue_controller #(
    parameter int STS_DEPTH = dma_ctrl_pkg::STS_DEPTH
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [dma_ctrl_pkg::ADDR_W-1:0] reg_address,
    input wire logic reg_read,
    input wire logic reg_write,
    input wire logic [dma_ctrl_pkg::REG_W-1:0] reg_writedata,
    input wire logic [dma_ctrl_pkg::BE_W-1:0] reg_byteenable,
    output logic reg_waitrequest,
    output logic [dma_ctrl_pkg::REG_W-1:0] reg_readdata,
    output logic reg_readdatavalid,
    output dma_ctrl_pkg::desc_t [3:0] desc_data,
    output logic [3:0] desc_valid,
    input wire logic [3:0] desc_ready,
    input wire logic [3:0][7:0] desc_fill,
    input wire dma_ctrl_pkg::status_t [1:0] mover_status,
    output logic [1:0] mover_status_ready
);
    // ========================================
    // decode helpers
    function automatic logic [1:0] chan_of(input logic [2:0] sel);
        return {sel[2], sel[0]};
    endfunction : chan_of

    function automatic logic [511:0] merge_bytes(input logic [511:0] old_v,
        input logic [511:0] new_v, input logic [63:0] be);
        logic [511:0] r;
        r = old_v;
        for (int i = 0; i < 64; i++)
        begin
            if (be[i])
            begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge_bytes

    function automatic logic [511:0] msi_image(
        input dma_ctrl_pkg::msi_ctrl_t m);
        logic [511:0] r;
        r = '0;
        r[dma_ctrl_pkg::MSI_EN_BIT] = m.enable;
        r[dma_ctrl_pkg::MSI_PRIO_BIT] = m.prio;
        r[dma_ctrl_pkg::MSI_DATA_LSB +: 16] = m.data;
        r[dma_ctrl_pkg::MSI_ADDR_LSB +: 64] = m.addr;
        return r;
    endfunction : msi_image

    function automatic dma_ctrl_pkg::msi_ctrl_t msi_fields(
        input logic [511:0] v);
        return {v[dma_ctrl_pkg::MSI_EN_BIT], v[dma_ctrl_pkg::MSI_PRIO_BIT],
            v[dma_ctrl_pkg::MSI_DATA_LSB +: 16],
            v[dma_ctrl_pkg::MSI_ADDR_LSB +: 64]};
    endfunction : msi_fields

    function automatic dma_ctrl_pkg::desc_t msi_desc(
        input dma_ctrl_pkg::msi_ctrl_t m);
        dma_ctrl_pkg::desc_t d;
        d = '0;
        d[15:0] = m.data;
        d[dma_ctrl_pkg::DESC_DST_LSB +: 64] = m.addr;
        d[dma_ctrl_pkg::DESC_LEN_LSB +: dma_ctrl_pkg::DESC_LEN_W] =
            dma_ctrl_pkg::MSI_LEN_DWORDS;
        d[dma_ctrl_pkg::DESC_IMM_BIT] = 1'b1;
        d[dma_ctrl_pkg::DESC_APP_LSB +: 3] =
            dma_ctrl_pkg::APP_DROP_NO_IRQ;
        return d;
    endfunction : msi_desc

    // ========================================
    // state
    dma_ctrl_pkg::desc_t [3:0] shadow_q, shadow_d;
    dma_ctrl_pkg::desc_t [3:0] out_q, out_d;
    logic [3:0] out_valid_q, out_valid_d;
    dma_ctrl_pkg::msi_ctrl_t [1:0] msi_q, msi_d;
    logic [1:0] pend_q, pend_d;
    logic [511:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;

    logic [2:0] sel;
    logic mapped, is_queue, msw_hit, trig, wait_req;
    logic [1:0] wch;
    logic [511:0] merged;
    logic [3:0] claimed;
    logic [1:0] fifo_in_ready, fifo_out_valid, fifo_pop, accept, push;
    logic [1:0][31:0] fifo_out;
    logic [1:0][31:0] push_word;
    logic [1:0] want_irq;

    assign sel = reg_address[dma_ctrl_pkg::SEL_LSB +: dma_ctrl_pkg::SEL_W];
    assign mapped = (reg_address >> dma_ctrl_pkg::MAP_TOP_LSB) == '0;
    assign is_queue = mapped && !sel[1];
    assign wch = chan_of(sel);
    assign msw_hit = |reg_byteenable[dma_ctrl_pkg::MSW_BE_LSB +:
        dma_ctrl_pkg::MSW_BE_W];
    assign trig = reg_write && is_queue && msw_hit;
    assign merged = merge_bytes({338'h0, shadow_q[wch]}, reg_writedata,
        reg_byteenable);

    // ========================================
    // status intake, one fifo per mover
    generate
        for (genvar m = 0; m < 2; m++)
        begin : g_mover
            logic [1:0] code;
            assign code = mover_status[m].word[dma_ctrl_pkg::STS_IRQ_LSB +: 2];
            assign mover_status_ready[m] = !pend_q[m] && fifo_in_ready[m];
            assign accept[m] = mover_status[m].valid && mover_status_ready[m];
            assign push[m] = accept[m] &&
                (code != dma_ctrl_pkg::IRQ_DROP);
            assign want_irq[m] = accept[m] &&
                ((code == dma_ctrl_pkg::IRQ_ALWAYS) ||
                 (code == dma_ctrl_pkg::IRQ_ON_ERROR &&
                  mover_status[m].word[dma_ctrl_pkg::STS_ERR_BIT]));
            assign push_word[m] = {1'b0,
                mover_status[m].word[dma_ctrl_pkg::STS_EMPTY_BIT-1:0]};
            assign fifo_pop[m] = reg_read && mapped &&
                sel[1:0] == dma_ctrl_pkg::SEL_KIND_STATUS &&
                sel[2] == 1'(m) && fifo_out_valid[m];

            status_fifo #(
                .WIDTH(dma_ctrl_pkg::STS_W),
                .DEPTH(STS_DEPTH)
            ) u_fifo (
                .core_clk(core_clk),
                .reset_n(reset_n),
                .in_valid(push[m]),
                .in_ready(fifo_in_ready[m]),
                .in_data(push_word[m]),
                .out_valid(fifo_out_valid[m]),
                .out_ready(fifo_pop[m]),
                .out_data(fifo_out[m])
            );
        end
    endgenerate

    // ========================================
    // msi scheduling, descriptor slots and register writes
    always_comb
    begin
        logic [1:0] tgt;
        tgt = '0;
        claimed = '0;
        out_d = out_q;
        out_valid_d = out_valid_q & ~desc_ready;
        pend_d = pend_q;
        msi_d = msi_q;
        shadow_d = shadow_q;
        for (int m = 0; m < 2; m++)
        begin
            if (want_irq[m] && msi_q[m].enable)
            begin
                pend_d[m] = 1'b1;
            end
            tgt = {1'b0, msi_q[m].prio};
            if (pend_q[m] && !out_valid_q[tgt] && !claimed[tgt])
            begin
                claimed[tgt] = 1'b1;
                out_d[tgt] = msi_desc(msi_q[m]);
                out_valid_d[tgt] = 1'b1;
                pend_d[m] = 1'b0;
            end
        end
        wait_req = trig && (!desc_ready[wch] || out_valid_q[wch] ||
            claimed[wch]);
        if (reg_write && is_queue && !wait_req)
        begin
            shadow_d[wch] = merged[dma_ctrl_pkg::DESC_W-1:0];
            if (trig)
            begin
                out_d[wch] = merged[dma_ctrl_pkg::DESC_W-1:0];
                out_valid_d[wch] = 1'b1;
            end
        end
        if (reg_write && mapped && sel[1:0] == dma_ctrl_pkg::SEL_KIND_MSI)
        begin
            msi_d[sel[2]] = msi_fields(merge_bytes(msi_image(msi_q[sel[2]]),
                reg_writedata, reg_byteenable));
        end
    end

    // ========================================
    // read path
    always_comb
    begin
        rdata_d = '0;
        rvalid_d = reg_read;
        if (reg_read && mapped)
        begin
            if (is_queue)
            begin
                rdata_d[dma_ctrl_pkg::READY_BIT] = desc_ready[wch];
                rdata_d[dma_ctrl_pkg::FILL_W-1:0] = desc_fill[wch];
            end
            else if (sel[1:0] == dma_ctrl_pkg::SEL_KIND_STATUS)
            begin
                rdata_d = fifo_out_valid[sel[2]] ? {{(dma_ctrl_pkg::REG_W -
                    dma_ctrl_pkg::STS_W){1'b0}}, fifo_out[sel[2]]} :
                    dma_ctrl_pkg::STS_EMPTY_WORD;
            end
            else
            begin
                rdata_d = msi_image(msi_q[sel[2]]);
            end
        end
    end

    // ========================================
    // registers, all on the application clock
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            shadow_q <= '0;
            out_q <= '0;
            out_valid_q <= '0;
            msi_q <= {dma_ctrl_pkg::MSI_RESET, dma_ctrl_pkg::MSI_RESET};
            pend_q <= '0;
            rdata_q <= '0;
            rvalid_q <= 1'b0;
        end
        else
        begin
            shadow_q <= shadow_d;
            out_q <= out_d;
            out_valid_q <= out_valid_d;
            msi_q <= msi_d;
            pend_q <= pend_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign reg_waitrequest = wait_req;
    assign reg_readdata = rdata_q;
    assign reg_readdatavalid = rvalid_q;
    assign desc_data = out_q;
    assign desc_valid = out_valid_q;
endmodule : dma_descriptor_queue_controller

`default_nettype wire

// file: dv/dma_ctrl_props.sv
// port checker for the descriptor queue controller
// assumes bind to the controller top, one clock domain
`default_nettype none

module dma_ctrl_props #(
    parameter int STS_DEPTH = 32
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [15:0] reg_address,
    input wire logic reg_read,
    input wire logic reg_write,
    input wire logic [511:0] reg_writedata,
    input wire logic [63:0] reg_byteenable,
    input wire logic reg_waitrequest,
    input wire logic [511:0] reg_readdata,
    input wire logic reg_readdatavalid,
    input wire dma_ctrl_pkg::desc_t [3:0] desc_data,
    input wire logic [3:0] desc_valid,
    input wire logic [3:0] desc_ready,
    input wire logic [3:0][7:0] desc_fill,
    input wire dma_ctrl_pkg::status_t [1:0] mover_status,
    input wire logic [1:0] mover_status_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ch;
    logic to_q;
    logic to_sts;
    logic [3:0] held;
    assign ch = {reg_address[11], reg_address[9]};
    assign to_q = reg_address[15:12] == 4'h0 && !reg_address[10];
    assign to_sts = reg_address[15:12] == 4'h0 && reg_address[10:9] == 2'h2;
    assign held = desc_valid & ~desc_ready;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // ========================================
    // register reads
    a_read_answer:
        assert property (reg_read |=> reg_readdatavalid)
        else $error("read not answered in one cycle");
    a_queue_fields:
        assert property (reg_read && to_q |=> reg_readdata == {480'h0,
            $past(desc_ready[ch]), 23'h0, $past(desc_fill[ch])})
        else $error("queue read fields wrong");
    a_status_upper_zero:
        assert property (reg_read && to_sts |=> reg_readdata[511:32] == '0
            && (!reg_readdata[31] || reg_readdata[30:0] == 31'h0))
        else $error("status read upper bits not zero");
    a_unmapped_zero:
        assert property (reg_read && reg_address[15:12] != 4'h0
            |=> reg_readdata == '0)
        else $error("unmapped read not zero");

    // ========================================
    // descriptor path
    a_wait_not_ready:
        assert property (reg_write && to_q && reg_byteenable[23:20] != 4'h0
            && !desc_ready[ch] |-> reg_waitrequest)
        else $error("write to unready queue not held");
    a_valid_holds:
        assert property (held != 4'h0 |=> (desc_valid & $past(held))
            == $past(held))
        else $error("descriptor dropped before accept");
    a_forward_msw:
        assert property (reg_write && !reg_waitrequest && to_q
            && reg_byteenable == '1 |=> desc_valid[$past(ch)]
            && desc_data[$past(ch)] == $past(reg_writedata[173:0]))
        else $error("full write not forwarded");

    // ========================================
    // status and msi
    a_drop_no_stall:
        assert property (mover_status[0].valid && mover_status_ready[0]
            && mover_status[0].word[13:12] == 2'h0 |=> mover_status_ready[0])
        else $error("dropped status stalled the stream");
    a_msi_desc_code:
        assert property ($rose(desc_valid[1]) && !$past(reg_write)
            |-> desc_data[1][146] && desc_data[1][151:149] == 3'h0)
        else $error("msi descriptor malformed");
endmodule : dma_ctrl_props

bind dma_descriptor_queue_controller dma_ctrl_props #(
    .STS_DEPTH(STS_DEPTH)
) u_props (.core_clk(core_clk), .reset_n(reset_n),
    .reg_address(reg_address), .reg_read(reg_read), .reg_write(reg_write),
    .reg_writedata(reg_writedata), .reg_byteenable(reg_byteenable),
    .reg_waitrequest(reg_waitrequest), .reg_readdata(reg_readdata),
    .reg_readdatavalid(reg_readdatavalid), .desc_data(desc_data),
    .desc_valid(desc_valid), .desc_ready(desc_ready),
    .desc_fill(desc_fill), .mover_status(mover_status),
    .mover_status_ready(mover_status_ready));

`default_nettype wire

// file: dv/mover_model.sv
// model of the read and write movers facing the controller
// assumes the bench pushes status words at the falling edge
`default_nettype none

module mover_model (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire dma_ctrl_pkg::desc_t [3:0] desc_data,
    input wire logic [3:0] desc_valid,
    output logic [3:0] desc_ready,
    output logic [3:0][7:0] desc_fill,
    output dma_ctrl_pkg::status_t [1:0] mover_status,
    input wire logic [1:0] mover_status_ready,
    input wire logic [3:0] stall
);
    timeunit 1ns;
    timeprecision 1ps;
    dma_ctrl_pkg::desc_t got[4][$];
    logic [31:0] pend[2][$];
    // queues never fill unless stalled, room for msi
    assign desc_ready = ~stall;

    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mover_status <= '0;
            desc_fill <= '0;
        end
        else
        begin
            // whole 174-bit descriptor taken per beat
            for (int i = 0; i < 4; i++)
                if (desc_valid[i] && desc_ready[i])
                begin
                    got[i].push_back(desc_data[i]);
                    desc_fill[i] <= desc_fill[i] + 8'h01;
                end
            for (int m = 0; m < 2; m++)
            begin
                if (mover_status[m].valid && mover_status_ready[m])
                    pend[m].delete(0);
                // idle word toggles so stale data never looks valid
                if (pend[m].size() > 0)
                    mover_status[m] <= {1'b1, pend[m][0]};
                else
                    mover_status[m] <= {1'b0, ~mover_status[m].word};
            end
        end
    end
endmodule : mover_model

`default_nettype wire

// file: dv/dma_descriptor_queue_controller_tb.sv
// self-checking bench for the descriptor queue controller
// assumes the mover model and the bound port checker
`default_nettype none

module dma_descriptor_queue_controller_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic reset_n;
    logic [15:0] reg_address;
    logic reg_read;
    logic reg_write;
    logic [511:0] reg_writedata;
    logic [63:0] reg_byteenable;
    logic reg_waitrequest;
    logic [511:0] reg_readdata;
    logic reg_readdatavalid;
    dma_ctrl_pkg::desc_t [3:0] desc_data;
    logic [3:0] desc_valid;
    logic [3:0] desc_ready;
    logic [3:0][7:0] desc_fill;
    dma_ctrl_pkg::status_t [1:0] mover_status;
    logic [1:0] mover_status_ready;
    logic [3:0] stall;
    int errors = 0;
    int tests_run = 0;
    int seed;

    always #10 core_clk = ~core_clk;

    dma_descriptor_queue_controller #(.STS_DEPTH(4)) dut (
        .core_clk(core_clk), .reset_n(reset_n),
        .reg_address(reg_address), .reg_read(reg_read),
        .reg_write(reg_write), .reg_writedata(reg_writedata),
        .reg_byteenable(reg_byteenable), .reg_waitrequest(reg_waitrequest),
        .reg_readdata(reg_readdata), .reg_readdatavalid(reg_readdatavalid),
        .desc_data(desc_data), .desc_valid(desc_valid),
        .desc_ready(desc_ready), .desc_fill(desc_fill),
        .mover_status(mover_status), .mover_status_ready(mover_status_ready));

    mover_model u_mover (.core_clk(core_clk), .reset_n(reset_n),
        .desc_data(desc_data), .desc_valid(desc_valid),
        .desc_ready(desc_ready), .desc_fill(desc_fill),
        .mover_status(mover_status), .mover_status_ready(mover_status_ready),
        .stall(stall));

    // ========================================
    // helpers
    task automatic print_verdict();
        if (errors == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [511:0] g, input logic [511:0] e);
        tests_run++;
        if (g !== e)
        begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    function automatic logic [511:0] rnd512();
        logic [511:0] v;
        for (int k = 0; k < 16; k++)
            v[32*k +: 32] = $random(seed);
        return v;
    endfunction : rnd512

    function automatic logic [15:0] qa(input int k);
        return {4'h0, k[1], 1'b0, k[0], 9'h0};
    endfunction : qa

    function automatic logic [511:0] msi_reg(input logic en,
        input logic pr, input logic [15:0] md, input logic [63:0] ma);
        return {en, pr, 414'h0, md, 16'h0, ma};
    endfunction : msi_reg

    function automatic dma_ctrl_pkg::desc_t msi_desc(
        input logic [63:0] ma, input logic [15:0] md);
        return {27'h0, 1'b1, 18'h00001, ma, 48'h0, md};
    endfunction : msi_desc

    task automatic rd(input logic [15:0] a, output logic [511:0] d);
        reg_address <= a;
        reg_read <= 1'b1;
        reg_write <= 1'b0;
        @(posedge core_clk);
        reg_read <= 1'b0;
        @(negedge core_clk);
        chk(reg_readdatavalid, 1'b1);
        d = reg_readdata;
        @(posedge core_clk);
    endtask : rd

    task automatic wr(input logic [15:0] a, input logic [511:0] d,
        input logic [63:0] be, output int n);
        logic w;
        reg_address <= a;
        reg_writedata <= d;
        reg_byteenable <= be;
        reg_write <= 1'b1;
        reg_read <= 1'b0;
        n = 0;
        do
        begin
            @(negedge core_clk);
            w = reg_waitrequest;
            @(posedge core_clk);
            if (w !== 1'b0)
                n++;
        end
        while (w !== 1'b0 && n < 200);
    endtask : wr

    task automatic push(input int m, input logic [31:0] w);
        @(negedge core_clk);
        u_mover.pend[m].push_back(w);
        @(posedge core_clk);
    endtask : push

    // ========================================
    // main sequence
    initial
    begin
        logic [511:0] d;
        logic [511:0] r;
        logic [511:0] ex[4];
        logic [31:0] w;
        logic [31:0] sq[$];
        logic [4:0] c;
        logic [63:0] ma;
        logic [15:0] md;
        logic irq;
        logic [4:0] cs[6];
        int n;
        int n0;
        seed = 91;
        cs = '{5'b11011, 5'b10101, 5'b10011, 5'b01111, 5'b11010, 5'b00011};
        reset_n = 1'b0;
        {reg_address, reg_read, reg_write} = '0;
        {reg_writedata, reg_byteenable, stall} = '0;
        repeat (10) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        for (int m = 0; m < 2; m++)
        begin
            rd({4'h0, m[0], 11'h600}, r);
            chk(r, 512'h0);
            rd({4'h0, m[0], 11'h400}, r);
            chk(r, dma_ctrl_pkg::STS_EMPTY_WORD);
        end
        for (int k = 0; k < 4; k++)
        begin
            d = rnd512();
            d[149] = 1'b1; // completion interrupt request
            ex[k] = d[173:0];
            wr(qa(k), d, '1, n);
        end
        rd(16'h1000, r);
        chk(r, 512'h0);
        for (int k = 0; k < 4; k++)
            chk(u_mover.got[k][$], ex[k]);
        stall[0] <= 1'b1;
        @(posedge core_clk);
        fork
            wr(qa(0), rnd512(), '1, n);
            begin
                repeat (5) @(posedge core_clk);
                stall[0] <= 1'b0;
            end
        join
        chk(n, 5);
        d = rnd512();
        wr(qa(3), d, '1, n);
        stall[3] <= 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            rd(qa(k), r);
            chk(r, {480'h0, ~stall[k], 23'h0, 8'(u_mover.got[k].size())});
        end
        stall[3] <= 1'b0;
        ex[3] = d[173:0];
        d = rnd512();
        n0 = u_mover.got[2].size();
        for (int k = 0; k < 6; k++)
            wr(qa(2), d, 64'hf << (4 * k), n);
        rd(16'h1000, r);
        chk(u_mover.got[2].size(), n0 + 1);
        chk(u_mover.got[2][$], d[173:0]);
        chk(u_mover.got[3][$], ex[3]);
        for (int k = 0; k < 5; k++)
        begin
            w = $random(seed);
            w[31] = 1'b0;
            w[13:12] = 2'h1;
            sq.push_back(w);
            push(1, w);
        end
        repeat (8) @(posedge core_clk);
        chk(u_mover.pend[1].size(), 1);
        for (int k = 0; k < 6; k++)
        begin
            rd(16'h0c00, r);
            chk(r, k < 5 ? {480'h0, sq[k]} : 512'h8000_0000);
        end
        for (int k = 0; k < 6; k++)
        begin
            c = cs[k];
            ma = {$random(seed), $random(seed)};
            md = 16'($random(seed));
            d = msi_reg(c[0], c[1], md, ma);
            wr({4'h0, k == 1, 11'h600}, d, '1, n);
            rd({4'h0, k == 1, 11'h600}, r);
            chk(r, d);
            n0 = u_mover.got[c[1]].size();
            w = $random(seed);
            w[31] = 1'b0;
            w[14] = c[2];
            w[13:12] = c[4:3];
            push(k == 1, w);
            repeat (8) @(posedge core_clk);
            irq = c[0] && (c[4:3] == 2'h3 || (c[4:3] == 2'h2 && c[2]));
            chk(u_mover.got[c[1]].size(), n0 + irq);
            if (irq)
                chk(u_mover.got[c[1]][$], msi_desc(ma, md));
            rd({4'h0, k == 1, 11'h400}, r);
            chk(r, c[4:3] == 2'h0 ? 512'h8000_0000 : {480'h0, w});
        end
        print_verdict();
    end

    initial
    begin
        repeat (5000) @(posedge core_clk);
        errors++;
        print_verdict();
    end
endmodule : dma_descriptor_queue_controller_tb

`default_nettype wire
